/* File: rtl/port_group_pkg.sv */
/*
 * constants for the digital i/o port group: register indices within the
 * special-register window, implemented-bit masks, reset values and clock choices.
 * assumes the cpu side presents the low byte of a window address.
 */
package port_group_pkg;

    // low byte of the window address where the port registers start
    localparam logic [7:0] PORT_BASE_OFF   = 8'h20;
    localparam int         NUM_REGS        = 10;

    // register indices, address = PORT_BASE_OFF + index
    localparam logic [3:0] IDX_G2_DATA     = 4'h0;  // group_two_data_latch
    localparam logic [3:0] IDX_G2_DIR      = 4'h1;  // group_two_direction_select
    localparam logic [3:0] IDX_G2_PU       = 4'h2;  // group_two_pullup_select
    localparam logic [3:0] IDX_G2_ALT      = 4'h3;  // group_two_alternate_select
    localparam logic [3:0] IDX_G3_DATA     = 4'h4;
    localparam logic [3:0] IDX_G3_DIR      = 4'h5;
    localparam logic [3:0] IDX_G3_PU       = 4'h6;
    localparam logic [3:0] IDX_G4_DATA     = 4'h7;
    localparam logic [3:0] IDX_G4_DIR      = 4'h8;
    localparam logic [3:0] IDX_G4_PU       = 4'h9;

    // bits that exist in each register, by index
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{
        8'h0f, 8'h0f, 8'h0f, 8'h0f,
        8'h04, 8'h04, 8'h04,
        8'h09, 8'hff, 8'h09
    };

    // direction bit 1 = input; every bit starts as input
    localparam logic [7:0] REG_RESET [NUM_REGS] = '{
        8'h00, 8'h0f, 8'h00, 8'h00,
        8'h00, 8'h04, 8'h00,
        8'h00, 8'hff, 8'h00
    };

    // bit positions inside group three
    localparam int G3_IO_BIT  = 2;
    localparam int G3_IN_BIT  = 4;

    // system clock source chosen by the option byte
    typedef enum logic [1:0] {
        CLK_INTERNAL_HS = 2'b00,
        CLK_CRYSTAL     = 2'b01,
        CLK_EXTERNAL    = 2'b10
    } clk_source_t;

endpackage

/* File: rtl/pin_sync.sv */
/*
 * three-flop input synchroniser with agreement filter, one lane per bit.
 * assumes inputs are asynchronous board levels; output lags by four edges.
 */
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 9
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // raw and filtered levels
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] level_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;

            // first flop feeds only the second, to keep metastability contained
            always_ff @(posedge mclk) begin
                s1_reg <= raw_in[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
            end

            // a change counts only once two settled stages agree
            always_ff @(posedge mclk) begin
                if (srst) begin
                    level_out[i] <= 1'b0;
                end else if (s2_reg == s3_reg) begin
                    level_out[i] <= s3_reg;
                end
            end
        end
    endgenerate

endmodule

/* File: rtl/digital_io_port_group.sv */
/*
 * digital i/o port group: four-bit group two, group three (bit 2 i/o, bit 4
 * input only) and two-bit group four, with per-bit direction and pull-up.
 * assumes a cpu-side special-register access port (1-bit or 8-bit writes,
 * registered reads) and board pins resolved by the surroundings from oe.
 * pin inputs arrive unsynchronised and are filtered here, so a read shows a
 * pin change only some clocks later; the clock choice is static outside reset.
 * direction bits use 1 = input, so every pin comes out of reset released.
 *
 * // Behaviour
 * // group two has four per-bit direction pins
 * // group four pins bits 0,3 per-bit direction
 * // group three bit 2 per-bit direction
 * // pull-up only when its select bit set
 * // group two bits 2,3 pulled down in reset
 * // internal oscillator frees group two bits 2,3
 * // external clock still frees group two bit 2
 * // software zeroes unused group four direction bits
 * // option bit enables reset-pin internal pull-up
 * // registers in 256-byte window, 1/8-bit access
 * // 16-bit accesses use even addresses
 * // reset gives inputs; group three bit 4 input-only
 * // read gives pin in input, latch in output
 */
`timescale 1ns/10ps
module digital_io_port_group
    import port_group_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // option byte settings
    input  wire logic [1:0]  clk_source,
    input  wire logic        reset_pin_pullup_option,
    // special-register access
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_bit_op,
    input  wire logic [2:0]  sfr_bit_sel,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // group two pins
    input  wire logic [3:0]  group_two_pin_in,
    output logic      [3:0]  group_two_pin_out,
    output logic      [3:0]  group_two_pin_oe,
    output logic      [3:0]  group_two_pullup_en,
    output logic      [1:0]  group_two_pulldown_en,
    // group three pins
    input  wire logic        group_three_bit2_in,
    output logic             group_three_bit2_out,
    output logic             group_three_bit2_oe,
    output logic             group_three_bit2_pullup_en,
    input  wire logic        group_three_bit4_input,
    output logic             reset_pin_pullup_en,
    // group four pins (lane 0 = bit 0, lane 1 = bit 3)
    input  wire logic [1:0]  group_four_pin_in,
    output logic      [1:0]  group_four_pin_out,
    output logic      [1:0]  group_four_pin_oe,
    output logic      [1:0]  group_four_pullup_en
);

    logic [7:0] regs_reg [NUM_REGS];
    logic [7:0] pin_level;
    logic [7:0] g2_level;
    logic [7:0] g3_level;
    logic [7:0] g4_level;
    logic [3:0] g2_avail;
    logic [7:0] offset;
    logic       hit;
    logic [3:0] idx;
    logic [7:0] g2_in_mode;
    logic [7:0] g2_read;
    logic [7:0] g3_read;
    logic [7:0] g4_read;
    logic [7:0] read_value;
    logic [3:0] g2_drive;
    logic [3:0] g2_pull;
    logic [1:0] g4_dir_lane;
    logic [1:0] g4_data_lane;
    logic [1:0] g4_pu_lane;

    // board pins come from another domain, so they are filtered first
    pin_sync #(
        .WIDTH (8)
    ) u_pin_sync (
        .mclk      (mclk),
        .srst      (srst),
        .raw_in    ({group_three_bit4_input, group_four_pin_in, group_three_bit2_in, group_two_pin_in}),
        .level_out (pin_level)
    );

    // pin levels placed at their register bit positions
    assign g2_level = {4'h0, pin_level[3:0]};
    assign g3_level = {3'h0, pin_level[7], 1'b0, pin_level[4], 2'b00};
    assign g4_level = {4'h0, pin_level[6], 2'b00, pin_level[5]};

    // oscillator terminals act as port bits only for some clock choices
    assign g2_avail[1:0] = 2'b11;
    assign g2_avail[2]   = (clk_source == CLK_INTERNAL_HS) || (clk_source == CLK_EXTERNAL);
    assign g2_avail[3]   = (clk_source == CLK_INTERNAL_HS);

    // address decode inside the 256-byte window; only low byte is seen
    assign offset = sfr_addr - PORT_BASE_OFF;
    assign hit    = (offset < 8'(NUM_REGS));
    assign idx    = offset[3:0];

    // merge a 1-bit or 8-bit write into the old value
    function automatic logic [7:0] merge_write(input logic [7:0] old_v, input logic [7:0] wd,
                                               input logic bit_op, input logic [2:0] sel);
        logic [7:0] res;
        res = wd;
        if (bit_op) begin
            res      = old_v;
            res[sel] = wd[0];
        end
        return res;
    endfunction

    // register file: only implemented bits store, rest read zero
    genvar r;
    generate
        for (r = 0; r < NUM_REGS; r++) begin : g_reg
            always_ff @(posedge mclk) begin
                if (srst) begin
                    regs_reg[r] <= REG_RESET[r];
                end else if (sfr_wr && hit && (idx == 4'(r))) begin
                    regs_reg[r] <= merge_write(regs_reg[r], sfr_wdata, sfr_bit_op, sfr_bit_sel)
                                   & REG_MASK[r];
                end
            end
        end
    endgenerate

    // group two input-mode bits: direction set, or alternate use releasing the driver
    assign g2_in_mode = regs_reg[IDX_G2_DIR] | regs_reg[IDX_G2_ALT];
    // latch bits of an oscillator terminal read zero while the clock owns the pin
    assign g2_read    = (g2_in_mode & g2_level)
                        | (~g2_in_mode & regs_reg[IDX_G2_DATA] & {4'h0, g2_avail});
    // bit 4 has no latch, so it always shows its pin
    assign g3_read    = (regs_reg[IDX_G3_DIR] & g3_level)
                        | (~regs_reg[IDX_G3_DIR] & regs_reg[IDX_G3_DATA])
                        | (g3_level & 8'h10);
    // only bits 0 and 3 have pins; the unused direction bits gate nothing
    assign g4_read    = (regs_reg[IDX_G4_DIR] & g4_level & 8'h09)
                        | (~regs_reg[IDX_G4_DIR] & regs_reg[IDX_G4_DATA]);

    // pick the addressed register; a miss reads zero so stray reads stay harmless
    always_comb begin
        read_value = 8'h00;
        if (hit) begin
            unique case (idx)
                IDX_G2_DATA: read_value = g2_read;
                IDX_G3_DATA: read_value = g3_read;
                IDX_G4_DATA: read_value = g4_read;
                default:     read_value = regs_reg[idx];
            endcase
        end
    end

    // read data is registered and holds until the next read
    always_ff @(posedge mclk) begin
        if (srst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= read_value;
        end
    end

    // a pin is driven only in output mode, with no alternate use and no clock claim
    assign g2_drive = ~regs_reg[IDX_G2_DIR][3:0] & ~regs_reg[IDX_G2_ALT][3:0] & g2_avail;
    // pull-up needs input mode as well, so it never fights the driver
    assign g2_pull  = regs_reg[IDX_G2_PU][3:0] & regs_reg[IDX_G2_DIR][3:0] & g2_avail;

    // group two drivers; unavailable bits and alternate bits stay released
    always_ff @(posedge mclk) begin
        if (srst) begin
            group_two_pin_out   <= 4'h0;
            group_two_pin_oe    <= 4'h0;
            group_two_pullup_en <= 4'h0;
        end else begin
            group_two_pin_out   <= regs_reg[IDX_G2_DATA][3:0];
            group_two_pin_oe    <= g2_drive;
            group_two_pullup_en <= g2_pull;
        end
    end

    // pull-down follows reset directly, so it holds from the first reset cycle
    assign group_two_pulldown_en = {2{srst}};

    // group three bit 2 driver; bit 4 has no driver at all
    always_ff @(posedge mclk) begin
        if (srst) begin
            group_three_bit2_out       <= 1'b0;
            group_three_bit2_oe        <= 1'b0;
            group_three_bit2_pullup_en <= 1'b0;
        end else begin
            group_three_bit2_out       <= regs_reg[IDX_G3_DATA][G3_IO_BIT];
            group_three_bit2_oe        <= ~regs_reg[IDX_G3_DIR][G3_IO_BIT];
            group_three_bit2_pullup_en <= regs_reg[IDX_G3_PU][G3_IO_BIT]
                                          & regs_reg[IDX_G3_DIR][G3_IO_BIT];
        end
    end

    // reset-pin pull-up is a pure option byte setting
    assign reset_pin_pullup_en = reset_pin_pullup_option;

    // group four lanes: lane 0 is bit 0, lane 1 is bit 3
    assign g4_dir_lane  = {regs_reg[IDX_G4_DIR][3], regs_reg[IDX_G4_DIR][0]};
    assign g4_data_lane = {regs_reg[IDX_G4_DATA][3], regs_reg[IDX_G4_DATA][0]};
    assign g4_pu_lane   = {regs_reg[IDX_G4_PU][3], regs_reg[IDX_G4_PU][0]};

    // group four drivers, bits 0 and 3; the other direction bits steer nothing
    always_ff @(posedge mclk) begin
        if (srst) begin
            group_four_pin_out   <= 2'b00;
            group_four_pin_oe    <= 2'b00;
            group_four_pullup_en <= 2'b00;
        end else begin
            group_four_pin_out   <= g4_data_lane;
            group_four_pin_oe    <= ~g4_dir_lane;
            group_four_pullup_en <= g4_pu_lane & g4_dir_lane;
        end
    end

endmodule

/* File: sim/digital_io_port_group_assertions.sv */
/*
 * concurrent checks on the port group's outputs, bound into the design.
 * assumes clk_source only changes under reset and writes are spaced apart.
 */
`timescale 1ns/10ps
module digital_io_port_group_assertions (
    // clock, reset and options
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic [1:0] clk_source,
    input wire logic       reset_pin_pullup_option,
    // register access
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic       sfr_bit_op,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // pin controls
    input wire logic [3:0] group_two_pin_oe,
    input wire logic [3:0] group_two_pullup_en,
    input wire logic [1:0] group_two_pulldown_en,
    input wire logic       group_three_bit2_oe,
    input wire logic [1:0] group_four_pin_oe,
    input wire logic       reset_pin_pullup_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // pull-down only while reset is high
    a_pulldown_off: assert property (group_two_pulldown_en == 2'b00)
        else $error("pull-down active outside reset");
    a_reset_inputs: assert property ($past(srst) |->
        !group_two_pin_oe && !group_four_pin_oe && !group_three_bit2_oe) else $error("driver on right after reset");
    // direction writes reach the drivers two edges later
    a_g2_input_off: assert property (sfr_wr && !sfr_bit_op && sfr_addr == 8'h21 ##1 !sfr_wr [*2] |->
        (group_two_pin_oe & $past(sfr_wdata[3:0], 2)) == 4'h0) else $error("input bit of group two drives");
    a_g3_dir_oe: assert property (sfr_wr && !sfr_bit_op && sfr_addr == 8'h25 ##1 !sfr_wr [*2] |->
        group_three_bit2_oe == !$past(sfr_wdata[2], 2)) else $error("group three driver wrong");
    a_g4_dir_oe: assert property (sfr_wr && !sfr_bit_op && sfr_addr == 8'h28 ##1 !sfr_wr [*2] |->
        group_four_pin_oe == ~{$past(sfr_wdata[3], 2), $past(sfr_wdata[0], 2)}) else $error("group four driver wrong");
    a_pullup_undriven: assert property ((group_two_pullup_en & group_two_pin_oe) == 4'h0)
        else $error("pull-up on a driven pin");
    a_bit3_needs_hs: assert property (clk_source != 2'b00 |->
        !group_two_pin_oe[3] && !group_two_pullup_en[3]) else $error("bit 3 used without internal clock");
    a_bit2_not_xtal: assert property (clk_source == 2'b01 |->
        !group_two_pin_oe[2] && !group_two_pullup_en[2]) else $error("bit 2 used with crystal");
    a_reset_pin_pu: assert property (reset_pin_pullup_en == reset_pin_pullup_option)
        else $error("reset pin pull-up differs from option");
    a_unmapped_zero: assert property (sfr_rd && (sfr_addr < 8'h20 || sfr_addr > 8'h29) |=>
        sfr_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

bind digital_io_port_group digital_io_port_group_assertions chk_i (.mclk, .srst, .clk_source, .reset_pin_pullup_option,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_bit_op, .sfr_wdata, .sfr_rdata, .group_two_pin_oe, .group_two_pullup_en,
    .group_two_pulldown_en, .group_three_bit2_oe, .group_four_pin_oe, .reset_pin_pullup_en);

/* File: sim/board_pins.sv */
/*
 * board model: resolves each pin lane from driver, bench drive and pulls.
 * assumes lanes g2[3:0], g3 bit2, g4 bit0, g4 bit3, reset/input pin.
 */
`timescale 1ns/10ps
module board_pins (
    // clock
    input  wire logic       mclk,
    // device and bench sides
    input  wire logic [7:0] oe,
    input  wire logic [7:0] dout,
    input  wire logic [7:0] pu,
    input  wire logic [7:0] pd,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] lvl
);
    logic [7:0] flt_reg = 8'h5a;
    // open lanes wander so a stale level is never read back
    always @(posedge mclk) flt_reg <= ~flt_reg;
    // driver, then bench, then pull-up, pull-down, else wander
    assign lvl = (oe & dout) | (~oe & ext_en & ext_val)
                 | (~oe & ~ext_en & (pu | (~pd & flt_reg)));
endmodule

/* File: sim/digital_io_port_group_tb_top.sv */
/*
 * self-checking bench: random register traffic against a register model.
 * assumes the board model on the pins and a bound checker.
 */
`timescale 1ns/10ps
module digital_io_port_group_tb_top;
    import port_group_pkg::*;
    logic       mclk = 0, srst = 1, rpo = 0, wr = 0, rd = 0, bop = 0, b, g3o, g3e, g3p, rpe;
    logic [1:0] cs = 0, g2d, g4o, g4e, g4p;
    logic [2:0] bsel = 0, s;
    logic [3:0] g2o, g2e, g2p, av, eo;
    logic [7:0] addr = 0, wd = 0, rdat, ext_en = 8'hff, ext_val = 0, lvl, a, d;
    logic [7:0] regs [NUM_REGS];
    int         n_errors = 0, samples_checked = 0, seed = 45044;
    digital_io_port_group digital_io_port_group_i (.mclk, .srst, .clk_source(cs), .reset_pin_pullup_option(rpo),
        .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_bit_op(bop), .sfr_bit_sel(bsel), .sfr_wdata(wd),
        .sfr_rdata(rdat), .group_two_pin_in(lvl[3:0]), .group_two_pin_out(g2o), .group_two_pin_oe(g2e),
        .group_two_pullup_en(g2p), .group_two_pulldown_en(g2d), .group_three_bit2_in(lvl[4]),
        .group_three_bit2_out(g3o), .group_three_bit2_oe(g3e), .group_three_bit2_pullup_en(g3p),
        .group_three_bit4_input(lvl[7]), .reset_pin_pullup_en(rpe), .group_four_pin_in(lvl[6:5]),
        .group_four_pin_out(g4o), .group_four_pin_oe(g4e), .group_four_pullup_en(g4p));
    board_pins board_pins_i (.mclk, .oe({1'b0, g4e, g3e, g2e}), .dout({1'b0, g4o, g3o, g2o}),
        .pu({rpe, g4p, g3p, g2p}), .pd({4'h0, g2d, 2'b00}), .ext_en, .ext_val, .lvl);
    // 100 MHz clock
    always #5 mclk = ~mclk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one strobe cycle, then one edge for the registered answer
    task automatic access(input logic w, input logic [7:0] ad, input logic [7:0] dd,
                          input logic bb, input logic [2:0] ss);
        @(posedge mclk); #1;
        wr = w; rd = !w; addr = ad; wd = dd; bop = bb; bsel = ss;
        @(posedge mclk); #1;
        wr = 0; rd = 0;
        @(posedge mclk); #1;
    endtask
    task automatic write(input logic [7:0] ad, input logic [7:0] dd, input logic bb, input logic [2:0] ss);
        access(1, ad, dd, bb, ss);
        if (ad >= 8'h20 && ad <= 8'h29) begin
            if (bb) regs[ad - 8'h20][ss] = dd[0];
            else regs[ad - 8'h20] = dd;
            regs[ad - 8'h20] &= REG_MASK[ad - 8'h20];
        end
    endtask
    // input bits show the pin, output bits the latch
    function automatic logic [7:0] exp_read(input logic [7:0] ad);
        logic [7:0] dr;
        dr = regs[1] | regs[3];
        case (ad)
            8'h20: return {4'h0, (dr[3:0] & ext_val[3:0]) | (~dr[3:0] & av & regs[0][3:0])};
            8'h24: return {3'b000, ext_val[7], 1'b0, regs[5][2] ? ext_val[4] : regs[4][2], 2'b00};
            8'h27: return {4'h0, regs[8][3] ? ext_val[6] : regs[7][3], 2'b00, regs[8][0] ? ext_val[5] : regs[7][0]};
            default: return (ad < 8'h20 || ad > 8'h29) ? 8'h00 : regs[ad - 8'h20];
        endcase
    endfunction
    task automatic verify;
        for (int i = 8'h1e; i < 8'h2b; i++) begin
            access(0, i[7:0], 8'h00, 0, 3'd0);
            check(rdat, exp_read(i[7:0]));
        end
        eo = ~regs[1][3:0] & ~regs[3][3:0] & av;
        check({g2e}, {eo});
        check({g2o & eo}, {regs[0][3:0] & eo});
        check({g3e}, {~regs[5][2]});
        check({g4e}, {~{regs[8][3], regs[8][0]}});
        check({g3o}, {regs[4][2]});
        check({g4o}, {regs[7][3], regs[7][0]});
        check({g2p & ~regs[3][3:0]}, {regs[2][3:0] & regs[1][3:0] & av & ~regs[3][3:0]});
        check({g4p, g3p}, {regs[9][3] & regs[8][3], regs[9][0] & regs[8][0], regs[6][2] & regs[5][2]});
        check({rpe}, {rpo});
    endtask
    // one reset and random traffic per clock choice
    initial begin
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk); #1;
            srst = 1;
            cs = k == 0 ? 2'b00 : k == 1 ? 2'b10 : 2'b01;
            av = k == 0 ? 4'hf : k == 1 ? 4'h7 : 4'h3;
            regs = REG_RESET;
            repeat (3) @(posedge mclk);
            #1;
            check({g2d}, 8'h03);
            check({g2e, g3e, g4e}, 8'h00);
            srst = 0;
            write(8'h28, 8'h09, 0, 3'd0);
            repeat (40) begin
                ext_val = $random(seed);
                rpo = $random(seed);
                a = 8'h1e + 8'({$random(seed)} % 13);
                d = $random(seed);
                b = $random(seed);
                s = $random(seed);
                if (a == 8'h28) begin
                    d &= 8'h09;
                    s = {1'b0, s[0], s[0]};
                end
                write(a, d, b, s);
                repeat (5) @(posedge mclk);
                verify;
            end
        end
        // open input with pull-up reads high
        ext_en = 8'hfe;
        write(8'h21, 8'h01, 1, 3'd0);
        // a 16-bit setting goes out as two single-bit writes, even address first
        write(8'h22, 8'h01, 1, 3'd0);
        write(8'h23, 8'h00, 1, 3'd0);
        repeat (5) @(posedge mclk);
        access(0, 8'h20, 8'h00, 0, 3'd0);
        check({rdat[0], g2p[0]}, 8'h03);
        print_verdict;
    end
    // hang guard, well past the expected run
    initial begin
        #200000;
        n_errors++;
        print_verdict;
    end
endmodule
